// ===== hw/ctl_pin_pkg.sv
// Constants, types and register layout for the control pin block
package ctl_pin_pkg;

	// Reference clock cycles per bus clock cycle
	localparam int E_DIV = 4;
	// Bus clock cycles within which a rising pin means internal
	localparam int CLASSIFY_E_CYCLES = 2;
	localparam int CLASSIFY_CYCLES = CLASSIFY_E_CYCLES * E_DIV;
	// Bus clock cycles the pin is pulled low on an internal failure
	localparam int DRIVE_E_CYCLES = 4;
	localparam int DRIVE_CYCLES = DRIVE_E_CYCLES * E_DIV;
	// Width of the reset sequencing counter
	localparam int CNT_W = 5;

	// Register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] MASK_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;

	// Control register fields
	localparam int CTRL_BCLK_OFF_BIT = 0;
	localparam int CTRL_IRQ_EDGE_BIT = 1;
	localparam int CTRL_STOP_BIT = 2;
	// Mask register fields
	localparam int MASK_I_BIT = 0;
	localparam int MASK_X_BIT = 1;

	// Values after reset
	localparam logic CTRL_BCLK_OFF_RST = 1'b0;
	localparam logic CTRL_IRQ_EDGE_RST = 1'b0;
	localparam logic CTRL_STOP_RST = 1'b0;
	localparam logic MASK_I_RST = 1'b1;
	localparam logic MASK_X_RST = 1'b1;
	// Idle level of the synchronised pins: all pulled high
	localparam logic [4:0] PIN_IDLE = 5'h1f;

	// Operating modes, indexed by {select_1, select_0}
	typedef enum logic [1:0] {
		MODE_BOOTSTRAP = 2'h0,
		MODE_TEST = 2'h1,
		MODE_SINGLE_CHIP = 2'h2,
		MODE_EXPANDED = 2'h3
	} op_mode_t;

	// Reset pin sequencer states
	typedef enum logic [3:0] {
		RST_RUN = 4'h1,
		RST_DRIVE = 4'h2,
		RST_RISE = 4'h4,
		RST_EXT = 4'h8
	} rst_state_t;

	// Software control bits
	typedef struct packed {
		logic stop;
		logic irq_edge;
		logic bus_clock_off;
	} ctrl_t;

	// Readable status word
	typedef struct packed {
		logic mode_valid;
		logic stopped;
		logic nonmaskable_interrupt_in_n_level;
		logic irq_level;
		logic irq_flag;
		logic reset_internal;
		op_mode_t mode;
	} status_t;

endpackage

// ===== hw/bus_clock_div.sv
// Divide-by-four bus clock generator with stop and output gating
`timescale 1ns/1ps
module bus_clock_div
	import ctl_pin_pkg::*;
#(
	parameter int DIV = E_DIV
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic run,
	input wire logic gate_off,
	output logic bus_clock,
	output logic access_phase,
	output logic cycle_end
);

	localparam int PW = $clog2(DIV);
	localparam logic [PW-1:0] LAST = PW'(DIV - 1);
	localparam logic [PW-1:0] HALF = PW'(DIV / 2);

	// Phase within one bus clock cycle
	logic [PW-1:0] phase_q;
	logic [PW-1:0] phase_d;

	// Wraps after the last phase
	always_comb
	begin
		phase_d = (phase_q == LAST) ? '0 : phase_q + 1'b1;
	end

	// Phase counter, frozen in stop so every clock halts
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			phase_q <= '0;
		else if (clk_en && run)
			phase_q <= phase_d;
	end

	// Low half internal work, high half data access
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			bus_clock <= 1'b0;
			access_phase <= 1'b0;
		end
		else if (clk_en && run)
		begin
			access_phase <= (phase_d >= HALF);
			bus_clock <= !gate_off && (phase_d >= HALF);
		end
		else if (clk_en)
			bus_clock <= bus_clock && !gate_off;
	end

	// Marks the final reference cycle of a bus cycle
	assign cycle_end = run && (phase_q == LAST);

endmodule

// ===== hw/ctl_pin_logic.sv
// Reset pin, bus clock, interrupt pins, mode latch and fetch indicator
`timescale 1ns/1ps
module ctl_pin_logic
	import ctl_pin_pkg::*;
#(
	parameter bit BUS_CLOCK_ALWAYS_ON = 1'b0,
	parameter int DIV = E_DIV
)
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic clock_monitor_fail,
	input wire logic watchdog_timeout,
	output logic chip_reset_n,
	output logic bus_clock_out,
	output logic access_phase,
	input wire logic mode_select_0,
	input wire logic mode_select_1,
	output op_mode_t op_mode,
	output logic mode_valid,
	input wire logic interrupt_in_n,
	input wire logic nonmaskable_interrupt_in_n,
	output logic irq_request,
	output logic nonmaskable_interrupt_in_n_request,
	input wire logic irq_ack,
	input wire logic nonmaskable_interrupt_in_n_ack,
	input wire logic opcode_fetch,
	output logic instruction_fetch_indicator_n,
	output logic instruction_fetch_indicator_oe,
	output logic stopped
);

	localparam logic [CNT_W-1:0] DRIVE_LAST = CNT_W'(DRIVE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CLASSIFY_N = CNT_W'(CLASSIFY_CYCLES);

	// Pin synchronisers: {nonmaskable_interrupt_in_n, irq, mode1, mode0, reset}
	logic [4:0] meta_q;
	logic [4:0] pin_q;
	// Previous synchronised maskable level, for edge detection
	logic irq_prev_q;
	// Reset sequencer
	rst_state_t rst_state_q;
	logic [CNT_W-1:0] cnt_q;
	// Last reset was classed internal
	logic reset_internal_q;
	// Latched mode and its validity
	op_mode_t mode_q;
	logic mode_valid_q;
	// Software control bits
	ctrl_t ctrl_q;
	// Interrupt mask bits
	logic i_mask_q;
	logic x_mask_q;
	// Pending falling edge on the maskable line
	logic irq_flag_q;
	// Fetch indicator state
	logic fetch_q;
	// Registered read data
	logic [7:0] rdata_q;

	// Decoded pin levels
	logic reset_pin_low;
	logic irq_low;
	logic nonmaskable_interrupt_in_n_low;
	logic in_reset;
	logic failure;
	logic irq_fall;
	logic single_chip;
	logic cycle_end;
	logic wr_ctrl;
	logic wr_mask;
	status_t status;

	// Two flip-flops on every pin before any logic looks at it; they keep
	// sampling through reset so the mode pins are known at its release
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			meta_q <= {nonmaskable_interrupt_in_n, interrupt_in_n,
				mode_select_1, mode_select_0, reset_pin_in};
			pin_q <= meta_q;
		end
	end

	assign reset_pin_low = !pin_q[0];
	assign irq_low = !pin_q[3];
	assign nonmaskable_interrupt_in_n_low = !pin_q[4];
	assign failure = clock_monitor_fail || watchdog_timeout;
	assign in_reset = (rst_state_q != RST_RUN);
	assign irq_fall = irq_prev_q && irq_low;
	assign single_chip = (mode_q == MODE_SINGLE_CHIP) ||
		(mode_q == MODE_BOOTSTRAP);
	assign wr_ctrl = wr_stb && (addr == CTRL_OFS);
	assign wr_mask = wr_stb && (addr == MASK_OFS);

	// Divider runs through reset so the rise can be timed in bus cycles
	bus_clock_div #(
		.DIV(DIV)
	) u_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.run(!ctrl_q.stop),
		.gate_off(ctrl_q.bus_clock_off && single_chip &&
			!BUS_CLOCK_ALWAYS_ON),
		.bus_clock(bus_clock_out),
		.access_phase(access_phase),
		.cycle_end(cycle_end)
	);

	// Reset sequencer; a power-up reset waits for the pin to go high
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rst_state_q <= RST_EXT;
			cnt_q <= '0;
		end
		else if (clk_en)
		begin
			case (rst_state_q)
				RST_RUN:
				begin
					cnt_q <= '0;
					// Own failures win over a pin seen low
					if (failure)
						rst_state_q <= RST_DRIVE;
					else if (reset_pin_low)
						rst_state_q <= RST_EXT;
				end
				RST_DRIVE:
				begin
					// Pin pulled low for a fixed count
					if (cnt_q == DRIVE_LAST)
					begin
						rst_state_q <= RST_RISE;
						cnt_q <= '0;
					end
					else
						cnt_q <= cnt_q + 1'b1;
				end
				RST_RISE:
				begin
					// Released; the synchroniser delay is part of the count
					if (!reset_pin_low)
						rst_state_q <= RST_RUN;
					else if (cnt_q == CLASSIFY_N)
						rst_state_q <= RST_EXT;
					else
						cnt_q <= cnt_q + 1'b1;
				end
				RST_EXT:
				begin
					// Someone outside still holds the pin low
					if (!reset_pin_low)
						rst_state_q <= RST_RUN;
				end
				default:
					rst_state_q <= RST_EXT;
			endcase
		end
	end

	// Reset cause: internal only if the pin rose inside the window
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			reset_internal_q <= 1'b0;
		else if (clk_en)
		begin
			if (rst_state_q == RST_RISE && !reset_pin_low &&
				cnt_q < CLASSIFY_N)
				reset_internal_q <= 1'b1;
			else if (rst_state_q == RST_EXT && !reset_pin_low)
				reset_internal_q <= 1'b0;
		end
	end

	// Open drain: only ever drives low, and only while sequencing
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = (rst_state_q == RST_DRIVE);
	assign chip_reset_n = !in_reset;

	// Mode pins caught on the cycle that reset is released
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			mode_q <= MODE_SINGLE_CHIP;
			mode_valid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (in_reset && !reset_pin_low)
			begin
				mode_q <= op_mode_t'(pin_q[2:1]);
				mode_valid_q <= 1'b1;
			end
			else if (in_reset)
				mode_valid_q <= 1'b0;
		end
	end

	assign op_mode = mode_q;
	assign mode_valid = mode_valid_q;

	// Control bits; reset forces level trigger and leaves stop
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ctrl_q.bus_clock_off <= CTRL_BCLK_OFF_RST;
			ctrl_q.irq_edge <= CTRL_IRQ_EDGE_RST;
			ctrl_q.stop <= CTRL_STOP_RST;
		end
		else if (clk_en)
		begin
			if (in_reset)
			begin
				ctrl_q.irq_edge <= CTRL_IRQ_EDGE_RST;
				ctrl_q.stop <= CTRL_STOP_RST;
			end
			else if (wr_ctrl)
			begin
				ctrl_q.bus_clock_off <= wdata[CTRL_BCLK_OFF_BIT];
				ctrl_q.irq_edge <= wdata[CTRL_IRQ_EDGE_BIT];
				ctrl_q.stop <= wdata[CTRL_STOP_BIT];
			end
			else if (ctrl_q.stop && ((irq_low && !i_mask_q) || nonmaskable_interrupt_in_n_low))
				ctrl_q.stop <= 1'b0;
		end
	end

	assign stopped = ctrl_q.stop;

	// Mask bits: entry to either service sets I, non-maskable entry also sets X; setting beats clearing
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			i_mask_q <= MASK_I_RST;
			x_mask_q <= MASK_X_RST;
		end
		else if (clk_en)
		begin
			if (in_reset)
			begin
				i_mask_q <= MASK_I_RST;
				x_mask_q <= MASK_X_RST;
			end
			else
			begin
				if (irq_ack || nonmaskable_interrupt_in_n_ack)
					i_mask_q <= 1'b1;
				else if (wr_mask)
					i_mask_q <= wdata[MASK_I_BIT];
				// Software may clear the bit but never set it again
				if (nonmaskable_interrupt_in_n_ack)
					x_mask_q <= 1'b1;
				else if (wr_mask && !wdata[MASK_X_BIT])
					x_mask_q <= 1'b0;
			end
		end
	end

	// Falling edge flag for edge mode; a new edge beats the acknowledge
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			irq_prev_q <= 1'b0;
			irq_flag_q <= 1'b0;
		end
		else if (clk_en)
		begin
			irq_prev_q <= !irq_low;
			if (in_reset || !ctrl_q.irq_edge)
				irq_flag_q <= 1'b0;
			else if (irq_fall)
				irq_flag_q <= 1'b1;
			else if (irq_ack)
				irq_flag_q <= 1'b0;
		end
	end

	// A level still held after service requests again once unmasked;
	// sources keep the line low until acknowledged, so level mode is safe
	assign irq_request = !in_reset && !i_mask_q &&
		(ctrl_q.irq_edge ? irq_flag_q : irq_low);
	// Non-maskable line: pure level, shareable as wired-OR
	assign nonmaskable_interrupt_in_n_request = !in_reset && !x_mask_q && nonmaskable_interrupt_in_n_low;

	// Indicator held low for the whole bus cycle of an opcode fetch
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			fetch_q <= 1'b0;
		else if (clk_en)
		begin
			if (in_reset || !mode_valid_q)
				fetch_q <= 1'b0;
			else if (cycle_end)
				fetch_q <= opcode_fetch;
		end
	end

	// Open drain; the pin doubles as a mode input during reset
	assign instruction_fetch_indicator_n = 1'b0;
	assign instruction_fetch_indicator_oe = fetch_q;

	// Status word
	always_comb
	begin
		status.mode_valid = mode_valid_q;
		status.stopped = ctrl_q.stop;
		status.nonmaskable_interrupt_in_n_level = nonmaskable_interrupt_in_n_low;
		status.irq_level = irq_low;
		status.irq_flag = irq_flag_q;
		status.reset_internal = reset_internal_q;
		status.mode = mode_q;
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			rdata_q <= 8'h00;
		else if (clk_en)
		begin
			if (!rd_stb)
				rdata_q <= 8'h00;
			else if (addr == CTRL_OFS)
				rdata_q <= {5'h00, ctrl_q};
			else if (addr == MASK_OFS)
				rdata_q <= {6'h00, x_mask_q, i_mask_q};
			else if (addr == STATUS_OFS)
				rdata_q <= status;
			else
				rdata_q <= 8'h00;
		end
	end

	assign rdata = rdata_q;

endmodule

// ===== testbench/ctl_pin_props.sv
// Timing properties watched at the control pin block's ports
`timescale 1ns/1ps
module ctl_pin_props
	import ctl_pin_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic watchdog_timeout,
	input wire logic clock_monitor_fail,
	input wire logic chip_reset_n,
	input wire logic reset_pin_oe,
	input wire logic bus_clock_out,
	input wire logic access_phase,
	input wire logic stopped,
	input wire logic nonmaskable_interrupt_in_n_request,
	input wire op_mode_t op_mode,
	input wire logic mode_valid,
	input wire logic instruction_fetch_indicator_oe
);
	// One clock domain, so clocking and reset are shared
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Failure while running pulls the pin low on the next edge
	property p_fail_drive;
		chip_reset_n && clk_en && (watchdog_timeout || clock_monitor_fail)
			|=> reset_pin_oe && !chip_reset_n;
	endproperty
	a_fail_drive: assert property (p_fail_drive)
		else $error("reset pin not driven after failure");

	// Own drive lasts exactly four bus cycles
	property p_drive_len;
		$rose(reset_pin_oe)
			|-> reset_pin_oe[*8] ##1 reset_pin_oe[*8] ##1 !reset_pin_oe;
	endproperty
	a_drive_len: assert property (p_drive_len)
		else $error("reset pin drive length wrong");

	// Low half of the bus clock spans two reference cycles
	property p_low_half;
		$fell(bus_clock_out) && !stopped |=> !bus_clock_out;
	endproperty
	a_low_half: assert property (p_low_half)
		else $error("bus clock low half too short");

	// Bus clock high only during the data access phase
	property p_access;
		bus_clock_out |-> access_phase;
	endproperty
	a_access: assert property (p_access)
		else $error("access phase not with high bus clock");

	// Slack of two cycles allows for a late freeze
	property p_stop_freeze;
		stopped[*3] |-> $stable(bus_clock_out);
	endproperty
	a_stop_freeze: assert property (p_stop_freeze)
		else $error("bus clock moved while stopped");

	// Non-maskable request stays masked after reset
	property p_xmask_reset;
		$rose(rst_b) |-> !nonmaskable_interrupt_in_n_request[*4];
	endproperty
	a_xmask_reset: assert property (p_xmask_reset)
		else $error("non-maskable request right after reset");

	// Indicator only once the mode is known and out of reset
	property p_fetch_mode;
		instruction_fetch_indicator_oe |-> mode_valid && chip_reset_n;
	endproperty
	a_fetch_mode: assert property (p_fetch_mode)
		else $error("fetch indicator before mode selected");

	// Indicator covers one whole bus cycle
	property p_fetch_len;
		$rose(instruction_fetch_indicator_oe)
			|-> instruction_fetch_indicator_oe[*4];
	endproperty
	a_fetch_len: assert property (p_fetch_len)
		else $error("fetch indicator shorter than a bus cycle");

	// Latched mode holds while running
	property p_mode_hold;
		mode_valid && chip_reset_n && $past(chip_reset_n) |-> $stable(op_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed while running");
endmodule

bind ctl_pin_logic ctl_pin_props props (.ref_clk, .rst_b, .clk_en,
	.watchdog_timeout, .clock_monitor_fail, .chip_reset_n, .reset_pin_oe,
	.bus_clock_out, .access_phase, .stopped, .nonmaskable_interrupt_in_n_request, .op_mode,
	.mode_valid, .instruction_fetch_indicator_oe);

// ===== testbench/board_model.sv
// Board side: pulled-up reset pin and shared interrupt sources
`timescale 1ns/1ps
module board_model
(
	input wire logic ref_clk,
	input wire logic reset_pin_oe,
	input wire logic hold_low,
	input wire logic [1:0] irq_post,
	input wire logic nonmaskable_interrupt_in_n_post,
	input wire logic irq_ack,
	input wire logic nonmaskable_interrupt_in_n_ack,
	output logic reset_pin_in,
	output logic interrupt_in_n,
	output logic nonmaskable_interrupt_in_n
);
	// Pending requests of the sources
	logic [1:0] pend_q = 2'h0;
	logic xpend_q = 1'b0;
	// Pull-up wins unless the device or the board pulls low
	assign reset_pin_in = !(reset_pin_oe || hold_low);
	// Open-drain sources wired onto one pulled-up line
	assign interrupt_in_n = !(|pend_q);
	assign nonmaskable_interrupt_in_n = !xpend_q;
	// Held low until acknowledged; lowest source served first
	always_ff @(posedge ref_clk)
	begin
		if (irq_ack)
			pend_q <= (pend_q & (pend_q - 2'h1)) | irq_post;
		else
			pend_q <= pend_q | irq_post;
		xpend_q <= (xpend_q && !nonmaskable_interrupt_in_n_ack) || nonmaskable_interrupt_in_n_post;
	end
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the control pin block
`timescale 1ns/1ps
module testbench
	import ctl_pin_pkg::*;
;
	logic ref_clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic rd_d = 1'b0, fetch_on = 1'b0, opcode_fetch = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic watchdog_timeout = 1'b0, clock_monitor_fail = 1'b0;
	logic hold_low = 1'b0, nonmaskable_interrupt_in_n_post = 1'b0, irq_ack = 1'b0, nonmaskable_interrupt_in_n_ack = 1'b0;
	logic [1:0] irq_post = 2'h0, msel = 2'h0;
	logic [31:0] seed = 32'hf777;
	logic reset_pin_in, interrupt_in_n, nonmaskable_interrupt_in_n;
	logic reset_pin_oe, chip_reset_n, bus_clock_out, stopped;
	logic irq_request, nonmaskable_interrupt_in_n_request;
	logic mode_valid;
	op_mode_t op_mode;
	logic [7:0] exp_q[$]; // Expected read data, oldest first
	int failures = 0, samples_checked = 0;

	ctl_pin_logic uut (.ref_clk, .rst_b, .clk_en(1'b1), .addr, .wdata,
		.wr_stb, .rd_stb, .rdata, .reset_pin_in, .reset_pin_out(),
		.reset_pin_oe, .clock_monitor_fail, .watchdog_timeout, .chip_reset_n,
		.bus_clock_out, .access_phase(), .mode_select_0(msel[0]),
		.mode_select_1(msel[1]), .op_mode, .mode_valid, .interrupt_in_n,
		.nonmaskable_interrupt_in_n, .irq_request, .nonmaskable_interrupt_in_n_request, .irq_ack,
		.nonmaskable_interrupt_in_n_ack, .opcode_fetch, .instruction_fetch_indicator_n(),
		.instruction_fetch_indicator_oe(), .stopped);
	board_model board (.ref_clk, .reset_pin_oe, .hold_low, .irq_post,
		.nonmaskable_interrupt_in_n_post, .irq_ack, .nonmaskable_interrupt_in_n_ack, .reset_pin_in, .interrupt_in_n,
		.nonmaskable_interrupt_in_n);

	always #20 ref_clk = ~ref_clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [7:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask

	// Expectation noted now, compared when the data appear
	task rd(input logic [7:0] a, exp);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(exp);
		@(posedge ref_clk);
		rd_stb <= 1'b0;
	endtask

	task ack(input logic x);
		@(posedge ref_clk);
		irq_ack <= !x;
		nonmaskable_interrupt_in_n_ack <= x;
		@(posedge ref_clk);
		irq_ack <= 1'b0;
		nonmaskable_interrupt_in_n_ack <= 1'b0;
	endtask

	task wait_run;
		for (int i = 0; i < 60 && chip_reset_n !== 1'b1; i++)
			@(negedge ref_clk);
		chk(chip_reset_n, 8'h01, "chip reset");
		chk(mode_valid, 8'h01, "mode valid");
	endtask

	// Any eight cycles of a running bus clock hold two rises
	task count_rises(input logic [7:0] exp);
		logic prev;
		logic [7:0] n;
		n = 8'h00;
		repeat (2) @(negedge ref_clk);
		prev = bus_clock_out;
		repeat (8)
		begin
			@(negedge ref_clk);
			if (bus_clock_out && !prev)
				n++;
			prev = bus_clock_out;
		end
		chk(n, exp, "bus clock rises");
	endtask

	// Two sources in level mode, one in edge mode
	task irq_case(input logic edge_m);
		wr(CTRL_OFS, {6'h00, edge_m, 1'b0});
		wr(MASK_OFS, 8'h02);
		@(posedge ref_clk);
		irq_post <= edge_m ? 2'h1 : 2'h3;
		@(posedge ref_clk);
		irq_post <= 2'h0;
		for (int i = 0; i < 8 && irq_request !== 1'b1; i++)
			@(negedge ref_clk);
		chk(irq_request, 8'h01, "irq request");
		if (edge_m)
			rd(STATUS_OFS, 8'h9b);
		ack(1'b0);
		repeat (2) @(negedge ref_clk);
		chk(irq_request, 8'h00, "irq after ack");
		wr(MASK_OFS, 8'h02);
		repeat (5) @(negedge ref_clk);
		chk(irq_request, {7'h00, !edge_m}, "irq again");
		if (!edge_m)
			ack(1'b0);
	endtask

	task fail_case(input logic wd, slow, input logic [7:0] exp);
		@(posedge ref_clk);
		watchdog_timeout <= wd;
		clock_monitor_fail <= !wd;
		@(posedge ref_clk);
		watchdog_timeout <= 1'b0;
		clock_monitor_fail <= 1'b0;
		hold_low <= slow;
		repeat (30) @(posedge ref_clk);
		hold_low <= 1'b0;
		wait_run();
		rd(STATUS_OFS, exp);
	endtask

	// Read data monitor and random fetch marks
	always @(posedge ref_clk)
	begin
		if (rd_d)
			chk(rdata, exp_q.pop_front(), "read data");
		rd_d <= rd_stb;
		seed <= lfsr(seed);
		opcode_fetch <= fetch_on & seed[0];
	end

	initial
	begin
		#2000000;
		failures++;
		test_done();
	end

	initial
	begin
		for (int m = 0; m < 4; m++)
		begin
			msel <= m[1:0];
			rst_b <= 1'b0;
			repeat (12) @(posedge ref_clk);
			rst_b <= 1'b1;
			wait_run();
			@(posedge ref_clk);
			msel <= ~m[1:0];
			rd(CTRL_OFS, 8'h00);
			rd(MASK_OFS, 8'h03);
			rd(STATUS_OFS, {6'h20, m[1:0]});
			chk(op_mode, {6'h00, m[1:0]}, "mode");
			wr(CTRL_OFS, 8'h01);
			count_rises(m[0] ? 8'h02 : 8'h00);
			wr(CTRL_OFS, 8'h00);
		end
		msel <= 2'h3;
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'h00);
		fetch_on <= 1'b1;
		irq_case(1'b0);
		irq_case(1'b1);
		fetch_on <= 1'b0;
		repeat (8) @(posedge ref_clk);
		wr(MASK_OFS, 8'h00);
		wr(CTRL_OFS, 8'h04);
		count_rises(8'h00);
		chk(stopped, 8'h01, "stopped");
		@(posedge ref_clk);
		nonmaskable_interrupt_in_n_post <= 1'b1;
		@(posedge ref_clk);
		nonmaskable_interrupt_in_n_post <= 1'b0;
		for (int i = 0; i < 8 && nonmaskable_interrupt_in_n_request !== 1'b1; i++)
			@(negedge ref_clk);
		chk(nonmaskable_interrupt_in_n_request, 8'h01, "nonmaskable_interrupt_in_n request");
		@(negedge ref_clk);
		chk(stopped, 8'h00, "woken");
		ack(1'b1);
		fail_case(1'b1, 1'b0, 8'h87);
		fail_case(1'b0, 1'b1, 8'h83);
		repeat (4) @(posedge ref_clk);
		test_done();
	end
endmodule
